/* rtl/dlbc_top.sv */
// Diagnostic LED blink code generator with its register slave
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// One blink report: flicker burst, code pulses, optional argument pulses, pause
module dlbc_seq
  import dlbc_pkg::*;
#(
  parameter int FLICK_HALF = FLICK_HALF_CYC,
  parameter int SLOW_HALF = SLOW_HALF_CYC,
  parameter int GAP = GAP_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic go,
  input wire logic [7:0] code,
  input wire logic [7:0] arg,
  output logic led,
  output logic idle,
  output logic done
);
  typedef enum logic [2:0] {S_IDLE, S_FLICK, S_GAP, S_ON, S_OFF, S_PAUSE} dlbc_seq_state_type;
  dlbc_seq_state_type state, next_state;
  logic [31:0] timer, next_timer;
  logic [7:0] cnt, next_cnt, a_q, next_a, b_q, next_b, target;
  logic phase, next_phase, next_led, next_done;

  assign target = phase ? b_q : a_q;
  assign idle = (state == S_IDLE);

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_cnt = cnt;
    next_phase = phase;
    next_a = a_q;
    next_b = b_q;
    next_led = led;
    next_done = 1'b0;
    if (timer != '0) begin
      next_timer = timer - 32'd1;
    end else begin
      case (state)
        S_IDLE: begin
          if (go) begin
            next_a = code;
            next_b = arg;
            next_phase = 1'b0;
            next_cnt = '0;
            next_led = 1'b1;
            next_timer = 32'(FLICK_HALF - 1);
            next_state = S_FLICK;
          end
        end
        S_FLICK: begin
          next_led = ~led;
          next_cnt = cnt + 8'd1;
          next_timer = 32'(FLICK_HALF - 1);
          if (cnt == FLICK_TOGGLES - 8'd1) begin
            next_led = 1'b0;
            next_cnt = '0;
            next_timer = 32'(GAP - 1);
            next_state = S_GAP;
          end
        end
        S_GAP: begin
          if (target != '0) begin
            next_led = 1'b1;
            next_timer = 32'(SLOW_HALF - 1);
            next_state = S_ON;
          end else begin
            next_timer = 32'(GAP - 1);
            next_state = S_PAUSE;
          end
        end
        S_ON: begin
          next_led = 1'b0;
          next_cnt = cnt + 8'd1;
          next_timer = 32'(SLOW_HALF - 1);
          next_state = S_OFF;
        end
        S_OFF: begin
          if (cnt != target) begin
            next_led = 1'b1;
            next_timer = 32'(SLOW_HALF - 1);
            next_state = S_ON;
          end else if (!phase && b_q != '0) begin
            next_phase = 1'b1;
            next_cnt = '0;
            next_timer = 32'(GAP - 1);
            next_state = S_GAP;
          end else begin
            next_timer = 32'(GAP - 1);
            next_state = S_PAUSE;
          end
        end
        S_PAUSE: begin
          // Whole code ends before the caller may start another
          next_done = 1'b1;
          next_state = S_IDLE;
        end
        default: next_state = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      timer <= '0;
      cnt <= '0;
      phase <= 1'b0;
      a_q <= '0;
      b_q <= '0;
      led <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      cnt <= next_cnt;
      phase <= next_phase;
      a_q <= next_a;
      b_q <= next_b;
      led <= next_led;
      done <= next_done;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_go_flicker: assert property (go && idle |=> state == S_FLICK && led)
    else $error("report did not open with flicker");
  a_pulse_bound: assert property (state == S_ON |-> cnt < target)
    else $error("more pulses than the code");
  a_code_stable: assert property (!idle |=> $stable(a_q) && $stable(b_q))
    else $error("code changed inside a report");
  a_arg_phase: assert property (state == S_GAP && phase |-> b_q != '0 && cnt == '0)
    else $error("argument sequence without argument");
endmodule

// How it works
// - Channel n current or open-load fault gives flicker then n pulses.
// - Field undervoltage gives five pulses, overvoltage six, after flicker.
// - Temperature low seven, high eight, difference nine pulses, after flicker.
// - Output circuit fault gives flicker then ten pulses.
// - Output and supply faults stay latched until acknowledge input falls.
// - Internal fault forces a shutdown that acknowledge cannot clear.
// - Internal fault lights first lamp; code lamp flashes only for first microcontroller.
// - Internal report starts with flicker, then error-code count of slow pulses.
// - Then, when code and argument are both nonzero, a second slow sequence counting the error argument.
// - Internal report repeats from flicker while the fault persists.
module dlbc_top
  import dlbc_pkg::*;
#(
  parameter int FLICK_HALF = FLICK_HALF_CYC,
  parameter int SLOW_HALF = SLOW_HALF_CYC,
  parameter int GAP = GAP_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [NUM_CHANNELS-1:0] channel_current_fault,
  input wire logic field_undervoltage,
  input wire logic field_overvoltage,
  input wire logic temp_too_low,
  input wire logic temp_too_high,
  input wire logic temp_difference,
  input wire logic output_circuit_fault,
  input wire logic err_ack,
  output logic output_fault_indicator,
  output logic internal_fault_indicator,
  output logic internal_fault_code_indicator,
  output logic shutdown,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Pin synchroniser: a change counts once stages two and three agree
  logic [SYNC_W-1:0] sync1, sync2, sync3, clean, next_clean, pins;
  logic ack_prev, ack_fall;
  logic [NUM_OUT_CODES-1:0] latched, next_latched, flags;
  logic [3:0] last_code, next_last_code, sel;
  logic out_led, out_idle, out_go;
  logic int_led, int_idle, int_go;
  logic src_first, next_src_first, next_shutdown;
  logic [7:0] err_code, next_err_code, err_arg, next_err_arg;

  assign pins = {err_ack, output_circuit_fault, temp_difference, temp_too_high, temp_too_low,
                 field_overvoltage, field_undervoltage, channel_current_fault};
  assign flags = clean[NUM_OUT_CODES-1:0];
  assign ack_fall = ack_prev && !clean[ACK_BIT];

  always_comb begin
    // Per bit, so a chattering pin cannot hold back the others
    next_clean = (sync2 & sync3) | (clean & (sync2 | sync3));
    // A fault arriving with the acknowledge edge stays latched
    next_latched = (ack_fall ? '0 : latched) | flags;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      clean <= '0;
      ack_prev <= 1'b0;
      latched <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      clean <= next_clean;
      ack_prev <= clean[ACK_BIT];
      latched <= next_latched;
    end
  end

  // Next code above the one last shown, wrapping to the lowest
  always_comb begin
    sel = '0;
    for (int i = NUM_OUT_CODES; i >= 1; i--) begin
      if (latched[i-1]) begin
        sel = 4'(i);
      end
    end
    for (int i = NUM_OUT_CODES; i >= 1; i--) begin
      if (latched[i-1] && 4'(i) > last_code) begin
        sel = 4'(i);
      end
    end
    next_last_code = out_go ? sel : last_code;
  end

  assign out_go = out_idle && (latched != '0);
  assign int_go = int_idle && shutdown && src_first;

  dlbc_seq #(.FLICK_HALF(FLICK_HALF), .SLOW_HALF(SLOW_HALF), .GAP(GAP)) u_out_seq (
    .clk(clk),
    .resetn(resetn),
    .go(out_go),
    .code({4'h0, sel}),
    .arg(8'h00),
    .led(out_led),
    .idle(out_idle),
    .done()
  );

  dlbc_seq #(.FLICK_HALF(FLICK_HALF), .SLOW_HALF(SLOW_HALF), .GAP(GAP)) u_int_seq (
    .clk(clk),
    .resetn(resetn),
    .go(int_go),
    .code(err_code),
    .arg(err_arg),
    .led(int_led),
    .idle(int_idle),
    .done()
  );

  // AXI4-Lite slave: one write and one read at a time
  logic aw_full, next_aw_full, w_full, next_w_full;
  logic [31:0] aw_addr, next_aw_addr, w_data, next_w_data, next_rdata;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic do_write, fault_first, fault_second;

  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign fault_first = w_strb[2] && w_data[IF_FIRST_BIT];
  assign fault_second = w_strb[2] && w_data[IF_SECOND_BIT];

  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_err_code = err_code;
    next_err_arg = err_arg;
    next_shutdown = shutdown;
    next_src_first = src_first;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (aw_addr[31:2] == ADDR_INT_FAULT[31:2]) begin
        // Report is frozen once shut down so the code stays readable
        if (!shutdown) begin
          if (w_strb[0]) next_err_code = w_data[IF_CODE_LSB +: 8];
          if (w_strb[1]) next_err_arg = w_data[IF_ARG_LSB +: 8];
          if (fault_first || fault_second) begin
            next_shutdown = 1'b1;
            next_src_first = fault_first;
          end
        end
      end else if (aw_addr[31:2] != ADDR_STATUS[31:2]) begin
        next_bresp = RESP_SLVERR;
      end
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready = !next_w_full && !next_bvalid;
  end

  always_comb begin
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = '0;
      next_rresp = RESP_OKAY;
      if (s_axi_araddr[31:2] == ADDR_STATUS[31:2]) begin
        next_rdata[ST_LATCHED_LSB +: NUM_OUT_CODES] = latched;
        next_rdata[ST_SHUTDOWN_BIT] = shutdown;
        next_rdata[ST_SRC_FIRST_BIT] = src_first;
      end else if (s_axi_araddr[31:2] == ADDR_INT_FAULT[31:2]) begin
        next_rdata[IF_CODE_LSB +: 8] = err_code;
        next_rdata[IF_ARG_LSB +: 8] = err_arg;
        next_rdata[IF_FIRST_BIT] = shutdown && src_first;
        next_rdata[IF_SECOND_BIT] = shutdown && !src_first;
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      err_code <= '0;
      err_arg <= '0;
      shutdown <= 1'b0;
      src_first <= 1'b0;
      last_code <= '0;
      output_fault_indicator <= 1'b0;
      internal_fault_indicator <= 1'b0;
      internal_fault_code_indicator <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      // Comes up after reset so no address is taken during it
      s_axi_arready <= next_arready || (!s_axi_arready && !s_axi_rvalid);
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      err_code <= next_err_code;
      err_arg <= next_err_arg;
      shutdown <= next_shutdown;
      src_first <= next_src_first;
      last_code <= next_last_code;
      output_fault_indicator <= out_led;
      internal_fault_indicator <= next_shutdown;
      internal_fault_code_indicator <= int_led && src_first;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ack_clears: assert property (ack_fall |=> (latched & ~$past(flags)) == '0)
    else $error("acknowledge edge left a fault latched");
  a_latch_holds: assert property (!ack_fall |=> (latched & $past(latched)) == $past(latched))
    else $error("latched fault lost without acknowledge");
  a_shutdown_sticky: assert property (shutdown |=> shutdown && internal_fault_indicator)
    else $error("shutdown cleared");
  a_code_off_second: assert property ((shutdown && !src_first) [*2] |-> !internal_fault_code_indicator)
    else $error("code lamp active for second source");
  a_repeat_report: assert property (int_go |=> !int_idle ##1 internal_fault_code_indicator)
    else $error("internal report not repeated");
  a_order_valid: assert property (out_go |-> latched[sel - 4'd1] && sel != '0)
    else $error("selected code not latched");
  c_out_report: cover property (out_go ##1 !out_idle);
  c_ack_edge: cover property (ack_fall && latched != '0);
  c_shutdown_first: cover property ($rose(shutdown) ##1 src_first);
  c_multi_fault: cover property (out_go && $countones(latched) > 1);
endmodule

/* rtl/dlbc_pkg.sv */
// Constants shared by the diagnostic LED blink code generator
package dlbc_pkg;
  // Timing of the blink codes, in milliseconds, and the clock period
  localparam int CLK_PERIOD_NS = 5;
  localparam int NS_PER_MS = 1_000_000;
  localparam int FLICK_HALF_MS = 25;
  localparam int SLOW_HALF_MS = 300;
  localparam int GAP_MS = 800;
  localparam int FLICK_HALF_CYC = FLICK_HALF_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int SLOW_HALF_CYC = SLOW_HALF_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int GAP_CYC = GAP_MS * NS_PER_MS / CLK_PERIOD_NS;
  // Edges of the flicker burst; even so that the burst ends dark
  localparam logic [7:0] FLICK_TOGGLES = 8'h10;

  // Output and supply fault codes: bit n-1 carries code n
  localparam int NUM_OUT_CODES = 10;
  localparam int NUM_CHANNELS = 4;
  localparam int SYNC_W = 11;
  localparam int ACK_BIT = 10;

  // Register map
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0000;
  localparam logic [31:0] ADDR_INT_FAULT = 32'h0000_0004;
  localparam int ST_LATCHED_LSB = 0;
  localparam int ST_SHUTDOWN_BIT = 16;
  localparam int ST_SRC_FIRST_BIT = 17;
  localparam int IF_CODE_LSB = 0;
  localparam int IF_ARG_LSB = 8;
  localparam int IF_FIRST_BIT = 16;
  localparam int IF_SECOND_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* tb/dlbc_led_decoder.sv */
// Front panel model: decodes a blink code lamp into counted pulse groups
`timescale 1ns/1ps

module dlbc_led_decoder #(
  parameter int FLICK_HALF = 4,
  parameter int SLOW_HALF = 8,
  parameter int GAP = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic led,
  output logic [7:0] group_total,
  output logic [7:0] last_count,
  output logic last_flick
);
  // Lit spans are split halfway between flicker and slow pulse; a long dark span ends a group
  localparam int LIT_SPLIT = (FLICK_HALF + SLOW_HALF) / 2;
  localparam int DARK_END = (SLOW_HALF + GAP) / 2;
  logic prev_led, flick, next_prev_led, next_flick, next_last_flick;
  logic [15:0] run, next_run;
  logic [7:0] count, next_count, next_group_total, next_last_count;

  always_comb begin
    next_prev_led = led;
    next_run = run + 16'h0001;
    next_count = count;
    next_flick = flick;
    next_group_total = group_total;
    next_last_count = last_count;
    next_last_flick = last_flick;
    if (led != prev_led) begin
      next_run = 16'h0001;
    end
    if (prev_led && !led) begin
      if (run >= LIT_SPLIT) begin
        next_count = count + 8'h01;
      end else begin
        next_flick = 1'b1;
        next_count = 8'h00;
      end
    end
    // Groups of zero pulses are dropped, so the gap after a burst is not a group
    if (!led && !prev_led && run == DARK_END && count != 8'h00) begin
      next_group_total = group_total + 8'h01;
      next_last_count = count;
      next_last_flick = flick;
      next_count = 8'h00;
      next_flick = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_led <= 1'b0;
      run <= 16'h0000;
      count <= 8'h00;
      flick <= 1'b0;
      group_total <= 8'h00;
      last_count <= 8'h00;
      last_flick <= 1'b0;
    end else begin
      prev_led <= next_prev_led;
      run <= next_run;
      count <= next_count;
      flick <= next_flick;
      group_total <= next_group_total;
      last_count <= next_last_count;
      last_flick <= next_last_flick;
    end
  end
endmodule

/* tb/tb_dlbc_top.sv */
// Self-checking bench for the blink code generator
`timescale 1ns/1ps

module tb_dlbc_top
  import dlbc_pkg::*;
;
  localparam int T_FLICK = 4;
  localparam int T_SLOW = 8;
  localparam int T_GAP = 12;
  logic clk = 1'b0, resetn = 1'b0, err_ack = 1'b0;
  logic [9:0] faults = 10'h000;
  logic ofi, ifi, ifci, shutdown;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] o_total, o_last, c_total, c_last, c;
  logic o_flick, c_flick, f;
  logic [31:0] d;
  int mismatches = 0, check_count = 0, lit;

  always #2.5 clk = ~clk;

  dlbc_top #(.FLICK_HALF(T_FLICK), .SLOW_HALF(T_SLOW), .GAP(T_GAP)) u_dut (
    .clk(clk), .resetn(resetn), .channel_current_fault(faults[3:0]), .field_undervoltage(faults[4]),
    .field_overvoltage(faults[5]), .temp_too_low(faults[6]), .temp_too_high(faults[7]),
    .temp_difference(faults[8]), .output_circuit_fault(faults[9]), .err_ack(err_ack),
    .output_fault_indicator(ofi), .internal_fault_indicator(ifi), .internal_fault_code_indicator(ifci),
    .shutdown(shutdown), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  dlbc_led_decoder #(.FLICK_HALF(T_FLICK), .SLOW_HALF(T_SLOW), .GAP(T_GAP)) u_out_dec (
    .clk(clk), .resetn(resetn), .led(ofi), .group_total(o_total), .last_count(o_last), .last_flick(o_flick));
  dlbc_led_decoder #(.FLICK_HALF(T_FLICK), .SLOW_HALF(T_SLOW), .GAP(T_GAP)) u_code_dec (
    .clk(clk), .resetn(resetn), .led(ifci), .group_total(c_total), .last_count(c_last), .last_flick(c_flick));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Registered slave outputs are read before the edge's updates land, i.e. as sampled at that edge
  task automatic axi_write(input logic [31:0] a, input logic [31:0] v, output logic [1:0] resp);
    bit aw_done, w_done;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_done = 0;
    w_done = 0;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_done = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_done = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic ack();
    err_ack <= 1'b1;
    repeat (8) @(posedge clk);
    err_ack <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  task automatic wait_grp(input bit code_lamp, output logic [7:0] cnt, output logic fl);
    logic [7:0] t0;
    int i;
    t0 = code_lamp ? c_total : o_total;
    for (i = 0; i < 3000 && (code_lamp ? c_total : o_total) === t0; i++) @(posedge clk);
    check("pulse_group_seen", i < 3000, 1'b1);
    cnt = code_lamp ? c_last : o_last;
    fl = code_lamp ? c_flick : o_flick;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    final_report();
  end

  initial begin
    do_reset();
    check("lamps_after_reset", {ofi, ifi, ifci, shutdown}, 4'h0);
    axi_read(ADDR_STATUS, d, r);
    check("status_after_reset", d, 32'h0000_0000);
    for (int n = 1; n <= NUM_OUT_CODES; n++) begin
      faults <= 10'h001 << (n - 1);
      repeat (8) @(posedge clk);
      faults <= 10'h000;
      repeat (4) @(posedge clk);
      axi_read(ADDR_STATUS, d, r);
      check("latched_fault", d, 32'h0000_0001 << (n - 1));
      ack();
      axi_read(ADDR_STATUS, d, r);
      check("cleared_fault", d, 32'h0000_0000);
      wait_grp(1'b0, c, f);
      check("output_pulses", c, n);
      check("output_flicker", f, 1'b1);
      repeat (20) @(posedge clk);
    end
    // Two faults together, one still present while the acknowledge falls
    faults <= 10'h044;
    repeat (8) @(posedge clk);
    faults <= 10'h040;
    wait_grp(1'b0, c, f);
    check("first_of_two", c, 8'h03);
    wait_grp(1'b0, c, f);
    check("second_of_two", c, 8'h07);
    ack();
    axi_read(ADDR_STATUS, d, r);
    check("present_fault_kept", d, 32'h0000_0040);
    faults <= 10'h000;
    repeat (8) @(posedge clk);
    ack();
    axi_read(ADDR_STATUS, d, r);
    check("all_cleared", d, 32'h0000_0000);
    repeat (600) @(posedge clk);
    // Internal fault from the first microcontroller
    axi_write(ADDR_INT_FAULT, 32'h0001_0203, r);
    check("int_write_resp", r, RESP_OKAY);
    repeat (3) @(posedge clk);
    check("shutdown_first", {shutdown, ifi}, 2'b11);
    wait_grp(1'b1, c, f);
    check("error_code", {f, c}, 9'h103);
    wait_grp(1'b1, c, f);
    check("error_arg", {f, c}, 9'h002);
    wait_grp(1'b1, c, f);
    check("report_repeat", {f, c}, 9'h103);
    ack();
    check("ack_no_clear", {shutdown, ifi}, 2'b11);
    axi_read(ADDR_STATUS, d, r);
    check("status_source", d[17:16], 2'b11);
    axi_write(ADDR_INT_FAULT, 32'h0002_0105, r);
    axi_read(ADDR_INT_FAULT, d, r);
    check("int_frozen", d, 32'h0001_0203);
    axi_write(ADDR_STATUS, 32'h0000_ffff, r);
    check("status_write_resp", r, RESP_OKAY);
    axi_write(32'h0000_0008, 32'h0000_0001, r);
    check("unmapped_write", r, RESP_SLVERR);
    axi_read(32'h0000_0008, d, r);
    check("unmapped_read", {r, d}, {RESP_SLVERR, 32'h0000_0000});
    // Internal fault from the second microcontroller: code lamp stays dark
    do_reset();
    check("reset_ends_shutdown", {shutdown, ifi}, 2'b00);
    axi_write(ADDR_INT_FAULT, 32'h0002_0105, r);
    repeat (3) @(posedge clk);
    check("shutdown_second", {shutdown, ifi}, 2'b11);
    lit = 0;
    repeat (400) begin
      @(posedge clk);
      if (ifci !== 1'b0) lit++;
    end
    check("code_lamp_dark", lit, 0);
    axi_read(ADDR_STATUS, d, r);
    check("status_second", d[17:16], 2'b01);
    // Both sources at once and no argument: first source wins, no second sequence
    do_reset();
    axi_write(ADDR_INT_FAULT, 32'h0003_0004, r);
    axi_read(ADDR_STATUS, d, r);
    check("status_both", d[17:16], 2'b11);
    wait_grp(1'b1, c, f);
    check("code_no_arg", {f, c}, 9'h104);
    wait_grp(1'b1, c, f);
    check("repeat_no_arg", {f, c}, 9'h104);
    final_report();
  end
endmodule
